// [design/oicr_top.sv]
/*
 * Output interface configuration register bank: soft reset, output bit
 * mapping and interface mode selection with fuse defaults, fuse load
 * trigger and the power-down control register.
 * Assumes an external controller on the serial programming port and
 * fuse-derived defaults given as parameters.
 */
`timescale 1ns/1ps
// What this block does
// - Writing one to bit 0 of the reset register returns all registers to defaults and the bit reads back zero.
// - The output bit mapping field decodes 001, 010, 011 and 100 as the four mapping variants, others unused.
// - A written output bit mapping only takes effect when the fuse load bit of register 0x13 is written.
// - The fuse load discards earlier power-down register writes, so they must be written again; the interface select register is kept.
// - After reset the fuse default interface variant is applied without controller action.
// - The mapping and mode fields read 000 until the controller writes them.
// - The override enable bit decides whether the mode select field replaces the default mode.
// - The mode select field decodes 011, 100 and 101 as two-wire, one-wire and half-wire.
// - A read has bit A15 set and A[14:12] zero, and data leave on falling serial clock edges.
module oicr_top
    import oicr_pkg::*;
#(
    parameter logic [2:0] FUSE_BIT_MAPPING = 3'h1,
    parameter logic [2:0] FUSE_INTERFACE_MODE = 3'h3
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic serial_port_select_n,
    input wire logic sclk,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_n,
    output logic [2:0] active_bit_mapping,
    output logic [2:0] active_interface_mode,
    output logic clock_buffer_power_down,
    output logic reference_amp_power_down,
    output logic channel_a_power_down,
    output logic global_power_down
);
    import oicr_pkg::*;

    oicr_reg_if bus ();

    logic soft_reset;
    logic fuse_load;
    logic [2:0] map_r;
    logic map_written_r;
    logic override_r;
    logic [2:0] mode_r;
    logic mode_written_r;
    logic [7:0] pdn_r;
    logic [2:0] active_map_r;
    logic [2:0] active_mode_r;
    logic [7:0] rdata_r;
    logic map_valid;
    logic mode_valid;

    ////////////////////////////////////////////////////////////////////////
    oicr_serial_port u_port (
        .clk_sys(clk_sys),
        .reset(reset),
        .serial_port_select_n(serial_port_select_n),
        .sclk(sclk),
        .sdio_in(sdio_in),
        .sdio_out(sdio_out),
        .sdio_oe_n(sdio_oe_n),
        .bus(bus.port_side)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write decode.
    assign soft_reset = bus.wr_stb && bus.addr == ADDR_SOFT_RESET && bus.wdata[SOFT_RESET_BIT];
    assign fuse_load = bus.wr_stb && bus.addr == ADDR_FUSE_LOAD && bus.wdata[FUSE_LOAD_BIT];

    always_comb begin
        unique case (map_r)
            MAP_TWO_WIRE_18_14, MAP_TWO_WIRE_16, MAP_ONE_WIRE, MAP_HALF_WIRE: map_valid = 1'b1;
            default: map_valid = 1'b0;
        endcase
    end

    always_comb begin
        unique case (mode_r)
            MODE_TWO_WIRE, MODE_ONE_WIRE, MODE_HALF_WIRE: mode_valid = 1'b1;
            default: mode_valid = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Interface select register. The fuse load keeps this register, as it
    // is the one meant to be written ahead of the load.
    always_ff @(posedge clk_sys) begin
        if (reset || soft_reset) begin
            map_r <= IF_SELECT_RESET[MAP_MSB:MAP_LSB];
            map_written_r <= 1'b0;
            override_r <= IF_SELECT_RESET[OVERRIDE_BIT];
            mode_r <= IF_SELECT_RESET[MODE_MSB:MODE_LSB];
            mode_written_r <= 1'b0;
        end else if (bus.wr_stb && bus.addr == ADDR_IF_SELECT) begin
            map_r <= bus.wdata[MAP_MSB:MAP_LSB];
            map_written_r <= 1'b1;
            override_r <= bus.wdata[OVERRIDE_BIT];
            mode_r <= bus.wdata[MODE_MSB:MODE_LSB];
            mode_written_r <= 1'b1;
        end
    end

    // Power-down control register; reserved bit 1 holds its reset value.
    always_ff @(posedge clk_sys) begin
        if (reset || soft_reset || fuse_load) begin
            pdn_r <= POWER_DOWN_RESET;
        end else if (bus.wr_stb && bus.addr == ADDR_POWER_DOWN) begin
            pdn_r <= (bus.wdata & POWER_DOWN_WMASK) | POWER_DOWN_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Applied mapping follows the fuse default until a fuse load picks up
    // a written valid code.
    always_ff @(posedge clk_sys) begin
        if (reset || soft_reset) begin
            active_map_r <= FUSE_BIT_MAPPING;
        end else if (fuse_load) begin
            active_map_r <= (map_written_r && map_valid) ? map_r : FUSE_BIT_MAPPING;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || soft_reset) begin
            active_mode_r <= FUSE_INTERFACE_MODE;
        end else begin
            active_mode_r <= (override_r && mode_valid) ? mode_r : FUSE_INTERFACE_MODE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Readback; self-clearing and unmapped locations read zero.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else begin
            unique case (bus.addr)
                ADDR_IF_SELECT: rdata_r <= {map_written_r ? map_r : 3'h0, 1'b0, override_r,
                                            mode_written_r ? mode_r : 3'h0};
                ADDR_POWER_DOWN: rdata_r <= pdn_r;
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    assign bus.rdata = rdata_r;
    assign active_bit_mapping = active_map_r;
    assign active_interface_mode = active_mode_r;
    assign clock_buffer_power_down = pdn_r[PD_CLKBUF_BIT];
    assign reference_amp_power_down = pdn_r[PD_REFAMP_BIT];
    assign channel_a_power_down = pdn_r[PD_CHAN_A_BIT];
    assign global_power_down = pdn_r[PD_GLOBAL_BIT];
endmodule : oicr_top

// [design/oicr_pkg.sv]
/*
 * Constants for the output interface configuration register bank:
 * register offsets, field positions, reset values, codes and frame layout.
 * Assumes nothing of its surroundings.
 */
package oicr_pkg;
    // Register offsets on the serial programming port.
    localparam logic [11:0] ADDR_SOFT_RESET = 12'h000;
    localparam logic [11:0] ADDR_IF_SELECT = 12'h007;
    localparam logic [11:0] ADDR_POWER_DOWN = 12'h008;
    localparam logic [11:0] ADDR_FUSE_LOAD = 12'h013;

    // Field positions.
    localparam int SOFT_RESET_BIT = 0;
    localparam int FUSE_LOAD_BIT = 0;
    localparam int MAP_MSB = 7;
    localparam int MAP_LSB = 5;
    localparam int OVERRIDE_BIT = 3;
    localparam int MODE_MSB = 2;
    localparam int MODE_LSB = 0;
    localparam int PD_CLKBUF_BIT = 5;
    localparam int PD_REFAMP_BIT = 4;
    localparam int PD_CHAN_A_BIT = 2;
    localparam int PD_GLOBAL_BIT = 0;

    // Reset values and the power-down write mask.
    localparam logic [7:0] IF_SELECT_RESET = 8'h00;
    localparam logic [7:0] POWER_DOWN_RESET = 8'h02;
    localparam logic [7:0] POWER_DOWN_WMASK = 8'h3F;

    // Output bit mapping codes.
    localparam logic [2:0] MAP_TWO_WIRE_18_14 = 3'h1;
    localparam logic [2:0] MAP_TWO_WIRE_16 = 3'h2;
    localparam logic [2:0] MAP_ONE_WIRE = 3'h3;
    localparam logic [2:0] MAP_HALF_WIRE = 3'h4;

    // Interface mode select codes.
    localparam logic [2:0] MODE_TWO_WIRE = 3'h3;
    localparam logic [2:0] MODE_ONE_WIRE = 3'h4;
    localparam logic [2:0] MODE_HALF_WIRE = 3'h5;

    // Serial frame: 16 header bits then 8 data bits.
    localparam logic [4:0] HEADER_BITS = 5'h10;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam int RW_BIT = 15;
endpackage : oicr_pkg

// [design/oicr_reg_if.sv]
/*
 * Carrier between the serial port slave and the register bank.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/1ps
interface oicr_reg_if;
    logic wr_stb;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport port_side (
        output wr_stb,
        output addr,
        output wdata,
        input rdata
    );
    modport bank_side (
        input wr_stb,
        input addr,
        input wdata,
        output rdata
    );
endinterface : oicr_reg_if

// [design/oicr_serial_port.sv]
/*
 * Serial programming port slave: synchronises the select, clock and data
 * pins into clk_sys, shifts in a 16-bit header and 8 data bits, issues a
 * write strobe or drives read data out on falling clock edges.
 * Assumes the serial clock is far slower than clk_sys (at least 3 clk_sys
 * periods per phase).
 */
`timescale 1ns/1ps
module oicr_serial_port
    import oicr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic serial_port_select_n,
    input wire logic sclk,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_n,
    oicr_reg_if.port_side bus
);
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] prev_r;
    logic sel_n;
    logic sclk_rise;
    logic sclk_fall;
    logic din;
    logic [4:0] cnt_r;
    logic [22:0] shift_r;
    logic read_r;
    logic rw_r;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; logic reads the second stage, and clock edge detection also reads a third.
    always_ff @(posedge clk_sys) begin
        sync1_r <= {serial_port_select_n, sclk, sdio_in};
        sync2_r <= sync1_r;
        prev_r <= sync2_r;
    end

    assign sel_n = sync2_r[2];
    assign din = sync2_r[0];
    assign sclk_rise = sync2_r[1] & ~prev_r[1];
    assign sclk_fall = ~sync2_r[1] & prev_r[1];

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (reset || sel_n) begin
            cnt_r <= 5'h00;
            shift_r <= 23'h000000;
        end else if (sclk_rise && cnt_r != FRAME_BITS) begin
            cnt_r <= cnt_r + 5'h01;
            shift_r <= {shift_r[21:0], din};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || sel_n) begin
            read_r <= 1'b0;
            rw_r <= 1'b0;
            bus.addr <= 12'h000;
        end else if (sclk_rise && cnt_r == HEADER_BITS - 5'h01) begin
            read_r <= shift_r[RW_BIT - 1] && shift_r[13:11] == 3'h0;
            // A set read bit blocks the write even when the read itself is refused.
            rw_r <= shift_r[RW_BIT - 1];
            bus.addr <= {shift_r[10:0], din};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bus.wr_stb <= 1'b0;
            bus.wdata <= 8'h00;
        end else begin
            bus.wr_stb <= !sel_n && sclk_rise && cnt_r == FRAME_BITS - 5'h01 && !rw_r;
            if (sclk_rise && cnt_r == FRAME_BITS - 5'h01) begin
                bus.wdata <= {shift_r[6:0], din};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data is launched most significant bit first on falling edges.
    always_ff @(posedge clk_sys) begin
        if (reset || sel_n || !read_r) begin
            sdio_out <= 1'b0;
            sdio_oe_n <= 1'b1;
        end else if (sclk_fall && cnt_r >= HEADER_BITS && cnt_r < FRAME_BITS) begin
            sdio_out <= bus.rdata[3'(5'h17 - cnt_r)];
            sdio_oe_n <= 1'b0;
        end
    end
endmodule : oicr_serial_port

// [tb/oicr_checker.sv]
/* Port checker for the output interface register bank.
   Assumes it is bound to oicr_top with the same fuse parameters. */
`timescale 1ns/1ps
module oicr_checker #(
    parameter logic [2:0] FUSE_BIT_MAPPING = 3'h1,
    parameter logic [2:0] FUSE_INTERFACE_MODE = 3'h3
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic serial_port_select_n,
    input wire logic sdio_oe_n,
    input wire logic [2:0] active_bit_mapping,
    input wire logic [2:0] active_interface_mode,
    input wire logic clock_buffer_power_down,
    input wire logic reference_amp_power_down,
    input wire logic channel_a_power_down,
    input wire logic global_power_down
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire logic [3:0] pd = {clock_buffer_power_down, reference_amp_power_down, channel_a_power_down, global_power_down};
    ////////////////////////////////////////////////////////////////
    a_reset_map: assert property ($past(reset) |-> active_bit_mapping == FUSE_BIT_MAPPING)
        else $error("mapping not fuse default after reset");
    a_reset_mode: assert property ($past(reset) |-> active_interface_mode == FUSE_INTERFACE_MODE)
        else $error("mode not fuse default after reset");
    a_reset_pd: assert property ($past(reset) |-> pd == 4'h0)
        else $error("power down not cleared by reset");
    a_map_frame: assert property (!$stable(active_bit_mapping) |-> !serial_port_select_n)
        else $error("mapping changed outside a frame");
    a_pd_frame: assert property (!$stable(pd) |-> !serial_port_select_n)
        else $error("power down changed outside a frame");
    a_oe_idle: assert property (serial_port_select_n [*5] |-> sdio_oe_n)
        else $error("sdio driven while deselected");
    a_oe_frame: assert property ($fell(sdio_oe_n) |-> !serial_port_select_n)
        else $error("sdio drive began outside a frame");
    a_map_code: assert property (active_bit_mapping inside {[3'h1:3'h4]})
        else $error("unused mapping applied");
    a_mode_code: assert property (active_interface_mode inside {[3'h3:3'h5]})
        else $error("unused mode applied");
    c_read: cover property ($fell(sdio_oe_n));
    c_map: cover property (!$stable(active_bit_mapping));
    c_mode: cover property (!$stable(active_interface_mode));
endmodule : oicr_checker

// [tb/oicr_ctl_model.sv]
/* Controller model on the serial programming port.
   Assumes clk_sys paces it; each serial clock phase lasts 5 cycles. */
`timescale 1ns/1ps
module oicr_ctl_model (
    input wire logic clk_sys,
    input wire logic sdio_out,
    input wire logic sdio_oe_n,
    output logic serial_port_select_n,
    output logic sclk,
    output logic sdio_drv,
    output logic drove
);
    initial begin
        serial_port_select_n = 1'b1;
        sclk = 1'b0;
        sdio_drv = 1'b0;
        drove = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wt
    // Released data line toggles so a stale bit cannot pass as read data.
    task automatic xfer(input logic [15:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
        logic [23:0] frm;
        frm = {hdr, wd};
        rd = 8'h00;
        drove = 1'b0;
        wt(1);
        serial_port_select_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdio_drv = (hdr[15] && i < 8) ? ~sdio_drv : frm[i];
            wt(5);
            if (!sdio_oe_n) drove = 1'b1;
            if (i < 8) rd[i] = sdio_oe_n ? sdio_drv : sdio_out;
            sclk = 1'b1;
            wt(5);
            sclk = 1'b0;
        end
        wt(10);
        serial_port_select_n = 1'b1;
        wt(5);
    endtask : xfer
endmodule : oicr_ctl_model

// [tb/test_output_interface_config_regs.sv]
/* Self-checking bench for the register bank.
   Assumes oicr_top, oicr_ctl_model and oicr_checker are compiled. */
`timescale 1ns/1ps
module test_output_interface_config_regs;
    import oicr_pkg::*;
    localparam logic [2:0] FM = 3'h2;
    localparam logic [2:0] FI = 3'h4;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic sel_n, sclk, sdio_drv, drove, sdio_out, sdio_oe_n;
    logic [2:0] map, mode, cur;
    logic [7:0] v, pdv;
    logic cb, ra, ca, gl;
    int mismatches = 0;
    int n_tests = 0;
    wire logic sdio_in = sdio_oe_n ? sdio_drv : sdio_out;
    wire logic [7:0] pd = {2'b00, cb, ra, 1'b0, ca, 1'b0, gl};
    always #5 clk_sys = ~clk_sys;
    oicr_top #(.FUSE_BIT_MAPPING(FM), .FUSE_INTERFACE_MODE(FI)) dut (.clk_sys(clk_sys), .reset(reset),
        .serial_port_select_n(sel_n), .sclk(sclk), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe_n(sdio_oe_n), .active_bit_mapping(map), .active_interface_mode(mode),
        .clock_buffer_power_down(cb), .reference_amp_power_down(ra), .channel_a_power_down(ca),
        .global_power_down(gl));
    oicr_ctl_model ctl (.clk_sys(clk_sys), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
        .serial_port_select_n(sel_n), .sclk(sclk), .sdio_drv(sdio_drv), .drove(drove));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] t;
        ctl.xfer({4'h0, a}, d, t);
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        ctl.xfer({4'h8, a}, 8'h00, d);
    endtask : rd
    function automatic logic [2:0] emap(input logic [2:0] c);
        return (c >= 3'h1 && c <= 3'h4) ? c : FM;
    endfunction : emap
    function automatic logic [2:0] emode(input logic en, input logic [2:0] c);
        return (en && c >= 3'h3 && c <= 3'h5) ? c : FI;
    endfunction : emode
    ////////////////////////////////////////////////////////////////
    initial begin
        v = 8'($urandom(32'hFA29D457));
        repeat (16) @(posedge clk_sys);
        #1 reset = 1'b0;
        repeat (4) @(posedge clk_sys);
        check("map", {5'h0, map}, {5'h0, FM});
        check("mode", {5'h0, mode}, {5'h0, FI});
        rd(ADDR_IF_SELECT, v); check("sel_rd", v, 8'h00);
        rd(ADDR_POWER_DOWN, v); check("pd_rd", v, POWER_DOWN_RESET);
        check("good_read_drove", {7'h0, drove}, 8'h01);
        rd(12'h0AB, v); check("unmapped", v, 8'h00);
        $display("test defaults done");
        cur = FM;
        for (int c = 0; c < 8; c++) begin
            pdv = 8'h02 | (8'($urandom()) & 8'h35);
            wr(ADDR_IF_SELECT, {c[2:0], 5'h00});
            check("map_hold", {5'h0, map}, {5'h0, cur});
            rd(ADDR_IF_SELECT, v); check("map_rd", v, {c[2:0], 5'h00});
            wr(ADDR_FUSE_LOAD, 8'h01);
            cur = emap(c[2:0]);
            check("map_set", {5'h0, map}, {5'h0, cur});
            wr(ADDR_POWER_DOWN, pdv);
            check("pd_set", pd, pdv & 8'h35);
            wr(ADDR_FUSE_LOAD, 8'h01);
            check("pd_load", pd, 8'h00);
            rd(ADDR_POWER_DOWN, v); check("pd_load_rd", v, POWER_DOWN_RESET);
        end
        $display("test mapping done");
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_IF_SELECT, {3'($urandom()), 1'b0, c[3], c[2:0]});
            check("mode", {5'h0, mode}, {5'h0, emode(c[3], c[2:0])});
            check("map_keep", {5'h0, map}, {5'h0, cur});
        end
        $display("test mode done");
        wr(ADDR_IF_SELECT, 8'h6B);
        wr(ADDR_FUSE_LOAD, 8'h01);
        wr(ADDR_POWER_DOWN, 8'h37);
        wr(ADDR_SOFT_RESET, 8'h01);
        check("sr_map", {5'h0, map}, {5'h0, FM});
        check("sr_mode", {5'h0, mode}, {5'h0, FI});
        check("sr_pd", pd, 8'h00);
        rd(ADDR_SOFT_RESET, v); check("sr_clear", v, 8'h00);
        rd(ADDR_IF_SELECT, v); check("sr_sel", v, 8'h00);
        $display("test soft reset done");
        ctl.xfer(16'h9007, 8'h00, v);
        check("bad_read", {7'h0, drove}, 8'h00);
        rd(ADDR_IF_SELECT, v); check("bad_read_nowr", v, 8'h00);
        $display("test bad read done");
        close_out();
    end
    initial begin
        #400000;
        mismatches++;
        close_out();
    end
endmodule : test_output_interface_config_regs
bind oicr_top oicr_checker #(.FUSE_BIT_MAPPING(FUSE_BIT_MAPPING), .FUSE_INTERFACE_MODE(FUSE_INTERFACE_MODE)) u_chk (
    .clk_sys(clk_sys), .reset(reset), .serial_port_select_n(serial_port_select_n), .sdio_oe_n(sdio_oe_n),
    .active_bit_mapping(active_bit_mapping), .active_interface_mode(active_interface_mode),
    .clock_buffer_power_down(clock_buffer_power_down), .reference_amp_power_down(reference_amp_power_down),
    .channel_a_power_down(channel_a_power_down), .global_power_down(global_power_down));
